/* load_sequencer.sv */
// Purpose: Sequences ROM image load and apply on a clock reconfiguration controller
// Assumes: Busy and ROM bits come from logic on ref_clk
// Notes: Image bit path is registered once to keep outputs on flip-flops
`timescale 1ns/1ps
module load_sequencer
    import load_seq_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // User request
    input wire logic update_request,
    input wire logic [SEL_W-1:0] image_select,
    // Controller handshake
    input wire logic busy,
    output logic load_strobe,
    output logic apply_strobe,
    // ROM data path
    input wire logic [NUM_IMAGES-1:0] rom_bits,
    output logic [SEL_W-1:0] mux_select,
    output logic image_bit,
    // Progress
    output logic [STATE_NUM_W-1:0] state_num
);
    seq_state_t state_r;
    seq_state_t state_nxt;
    logic update_request_int;
    logic [SEL_W-1:0] sel_r;

    function automatic logic [STATE_NUM_W-1:0] state_code(input seq_state_t s);
        case (s)
            S_IDLE: state_code = NUM_IDLE;
            S_LOAD: state_code = NUM_LOAD;
            S_LOAD_WAIT_BUSY: state_code = NUM_LOAD_WAIT_BUSY;
            S_LOAD_WAIT_DONE: state_code = NUM_LOAD_WAIT_DONE;
            S_APPLY: state_code = NUM_APPLY;
            S_APPLY_WAIT_BUSY: state_code = NUM_APPLY_WAIT_BUSY;
            S_APPLY_WAIT_DONE: state_code = NUM_APPLY_WAIT_DONE;
            default: state_code = NUM_IDLE;
        endcase
    endfunction

    // Request with select free of unknowns
    assign update_request_int = update_request && !$isunknown(image_select); // see RL1

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (update_request_int) begin
                    state_nxt = S_LOAD; // see RL1
                end
            end
            S_LOAD: begin
                state_nxt = S_LOAD_WAIT_BUSY; // see RL4
            end
            S_LOAD_WAIT_BUSY: begin
                if (busy) begin
                    state_nxt = S_LOAD_WAIT_DONE; // see RL4
                end
            end
            S_LOAD_WAIT_DONE: begin
                if (!busy) begin
                    state_nxt = S_APPLY; // see RL5
                end
            end
            S_APPLY: begin
                state_nxt = S_APPLY_WAIT_BUSY; // see RL14
            end
            S_APPLY_WAIT_BUSY: begin
                if (busy) begin
                    state_nxt = S_APPLY_WAIT_DONE; // see RL14
                end
            end
            S_APPLY_WAIT_DONE: begin
                if (!busy) begin
                    state_nxt = S_IDLE; // see RL15
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= S_IDLE; // see RL17
        end else begin
            state_r <= state_nxt;
        end
    end

    // Progress code
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_num <= NUM_IDLE; // see RL17
        end else begin
            state_num <= state_code(state_nxt); // see RL12
        end
    end

    // Strobes, high while in state 1 and state 4
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            load_strobe <= 1'b0; // see RL17
            apply_strobe <= 1'b0; // see RL17
        end else begin
            load_strobe <= (state_nxt == S_LOAD); // see RL2
            apply_strobe <= (state_nxt == S_APPLY); // see RL13
        end
    end

    // Image select capture and multiplexer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sel_r <= '0;
        end else if (state_r == S_IDLE && update_request_int) begin
            sel_r <= image_select; // see RL3
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mux_select <= '0;
            image_bit <= 1'b0;
        end else begin
            mux_select <= (state_r == S_IDLE && update_request_int) ? image_select : sel_r;
            image_bit <= rom_bits[mux_select]; // see RL3 see RL11 see RL16
        end
    end

    // Checks
    a_idle_holds: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == S_IDLE && !update_request |=> state_r == S_IDLE) // see RL1
        else $error("idle left without request");
    a_load_strobe_one: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == S_IDLE && update_request_int |=> load_strobe ##1 !load_strobe) // see RL2
        else $error("load strobe not one cycle after request");
    a_select_routed: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == S_IDLE && update_request_int |=> mux_select == $past(image_select)) // see RL3
        else $error("mux select not taken from image select");
    a_load_busy_wait: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == S_LOAD |=> state_r == S_LOAD_WAIT_BUSY) // see RL4
        else $error("state 1 did not pass to state 2");
    a_load_done: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == S_LOAD_WAIT_DONE && !busy |=> apply_strobe ##1 !apply_strobe) // see RL5
        else $error("apply strobe not after load done");
    a_state_visible: assert property (@(posedge ref_clk) disable iff (rst)
        state_num == state_code(state_r)) // see RL12
        else $error("state number mismatch");
    a_apply_to_wait: assert property (@(posedge ref_clk) disable iff (rst)
        apply_strobe |-> state_num == NUM_APPLY ##1 state_num == NUM_APPLY_WAIT_BUSY) // see RL13
        else $error("apply strobe outside state 4");
    a_apply_busy: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == S_APPLY_WAIT_BUSY && busy |=> state_num == NUM_APPLY_WAIT_DONE) // see RL14
        else $error("state 5 did not follow busy");
    a_return_idle: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == S_APPLY_WAIT_DONE && !busy |=> state_num == NUM_IDLE) // see RL15
        else $error("state 6 did not return to idle");
    a_bit_latency: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 image_bit == $past(rom_bits[mux_select])) // see RL16
        else $error("image bit not one stage after mux");

    // Waiting states hold until busy changes; state 4 passes straight to state 5
    a_load_wait_hold: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == S_LOAD_WAIT_BUSY && !busy |=> state_r == S_LOAD_WAIT_BUSY) // see RL4
        else $error("state 2 left before busy");
    a_load_copy_hold: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == S_LOAD_WAIT_DONE && busy |=> state_r == S_LOAD_WAIT_DONE) // see RL5
        else $error("state 3 left while busy");
    a_apply_wait_hold: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == S_APPLY_WAIT_BUSY && !busy |=> state_r == S_APPLY_WAIT_BUSY) // see RL14
        else $error("state 5 left before busy");
    a_apply_done_hold: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == S_APPLY_WAIT_DONE && busy |=> state_r == S_APPLY_WAIT_DONE) // see RL15
        else $error("state 6 left while busy");
    a_apply_after_pulse: assert property (@(posedge ref_clk) disable iff (rst)
        state_r == S_APPLY |=> state_r == S_APPLY_WAIT_BUSY) // see RL14
        else $error("state 4 did not pass to state 5");

    // Strobes only in their own states
    a_strobes_apart: assert property (@(posedge ref_clk) disable iff (rst)
        !(load_strobe && apply_strobe)) // see RL2
        else $error("load and apply strobes together");
    a_load_in_one: assert property (@(posedge ref_clk) disable iff (rst)
        load_strobe |-> state_r == S_LOAD) // see RL2
        else $error("load strobe outside state 1");
    a_apply_in_four: assert property (@(posedge ref_clk) disable iff (rst)
        apply_strobe |-> state_r == S_APPLY) // see RL13
        else $error("apply strobe outside state 4");

    // Requests outside idle leave the selection alone
    a_refused_request: assert property (@(posedge ref_clk) disable iff (rst)
        state_r != S_IDLE |=> mux_select == $past(mux_select)) // see RL3
        else $error("mux select changed outside idle");

    // State encoding stays legal
    a_state_onehot: assert property (@(posedge ref_clk) disable iff (rst)
        $onehot(state_r)) // see RL12
        else $error("state register not one-hot");
    a_num_in_range: assert property (@(posedge ref_clk) disable iff (rst)
        state_num <= NUM_APPLY_WAIT_DONE) // see RL12
        else $error("state number above 6");

    c_full_cycle: cover property (@(posedge ref_clk) disable iff (rst)
        state_r == S_APPLY_WAIT_DONE ##1 state_r == S_IDLE);
    c_load_start: cover property (@(posedge ref_clk) disable iff (rst) load_strobe);
    c_image_three: cover property (@(posedge ref_clk) disable iff (rst)
        load_strobe && mux_select == 2'h3);
    c_long_load: cover property (@(posedge ref_clk) disable iff (rst)
        state_r == S_LOAD_WAIT_DONE [*8]);
    c_refused_poke: cover property (@(posedge ref_clk) disable iff (rst)
        state_r != S_IDLE && update_request);
endmodule

/* load_seq_pkg.sv */
// Purpose: Constants and state codes for the image load sequencer
// Assumes: Single 10 MHz clock, asynchronous active-high reset
// Notes: State numbers are the observable progress codes
// Behaviour
// RL1: Idle holds until request with valid select
// RL2: Leaving idle asserts load-image strobe
// RL3: Image select drives the ROM multiplexer
// RL4: State 1 to 2; wait busy rise
// RL5: State 3 holds while busy; then 4
// RL6: Controller holds busy through each operation
// RL7: Controller fetch enable reads all ROMs
// RL8: Controller drives shared 8-bit fetch index
// RL9: Fetch enable rises one cycle after busy
// RL10: Request is one-cycle pulse, select ready
// RL11: Enabled ROM bit forwarded to controller
// RL12: Current state number 0-6 is visible
// RL13: State 4 pulses apply strobe one clock
// RL14: State 5 waits busy, then state 6
// RL15: State 6 waits busy low, then idle
// RL16: Bits 0..233 streamed, two-clock latency
// RL17: Reset returns idle, strobes deasserted
package load_seq_pkg;
    localparam int SEL_W = 2;
    localparam int NUM_IMAGES = 4;
    localparam int STATE_NUM_W = 3;
    localparam int IMAGE_BITS = 234;
    localparam int ROM_LATENCY = 2;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_LOAD = 7'h02,
        S_LOAD_WAIT_BUSY = 7'h04,
        S_LOAD_WAIT_DONE = 7'h08,
        S_APPLY = 7'h10,
        S_APPLY_WAIT_BUSY = 7'h20,
        S_APPLY_WAIT_DONE = 7'h40
    } seq_state_t;

    localparam logic [STATE_NUM_W-1:0] NUM_IDLE = 3'h0;
    localparam logic [STATE_NUM_W-1:0] NUM_LOAD = 3'h1;
    localparam logic [STATE_NUM_W-1:0] NUM_LOAD_WAIT_BUSY = 3'h2;
    localparam logic [STATE_NUM_W-1:0] NUM_LOAD_WAIT_DONE = 3'h3;
    localparam logic [STATE_NUM_W-1:0] NUM_APPLY = 3'h4;
    localparam logic [STATE_NUM_W-1:0] NUM_APPLY_WAIT_BUSY = 3'h5;
    localparam logic [STATE_NUM_W-1:0] NUM_APPLY_WAIT_DONE = 3'h6;
endpackage

/* ctl_model.sv */
// Purpose: Behavioural reconfiguration controller with four serial ROMs
// Assumes: Busy rises lag cycles after a strobe
// Notes: ROM bus toggles while not read
`timescale 1ns/1ps
module ctl_model (
    // Clock, reset and strobes
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic load_strobe,
    input wire logic apply_strobe,
    input wire logic [3:0] lag,
    // Handshake and ROM side
    output logic busy,
    output logic fetch_en,
    output logic [7:0] fetch_idx,
    output logic [3:0] rom_bits
);
    int t;
    logic ld;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            t <= 0;
            ld <= 1'b0;
        end else if (load_strobe || apply_strobe) begin
            t <= 1;
            ld <= load_strobe;
        end else if (t != 0) begin
            t <= (t > lag + (ld ? 237 : 6)) ? 0 : t + 1;
        end
    end
    assign busy = t > lag && t <= lag + (ld ? 237 : 6);
    assign fetch_en = ld && t > lag + 1 && t <= lag + 235;
    assign fetch_idx = fetch_en ? 8'(t - lag - 2) : 8'h00;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) rom_bits <= 4'h0;
        else rom_bits <= fetch_en ? (fetch_idx[3:0] ^ {4{fetch_idx[5]}}) : ~rom_bits;
    end
endmodule

/* load_sequencer_bench.sv */
// Purpose: Self-checking bench for the image load sequencer
// Assumes: Controller model on the far side
// Notes: Random busy lag per load
`timescale 1ns/1ps
module load_sequencer_bench;
    import load_seq_pkg::*;
    logic ref_clk = 0, rst = 1, update_request = 0, busy, fetch_en, live = 0;
    logic load_strobe, apply_strobe, image_bit;
    logic [SEL_W-1:0] image_select = 0, mux_select, prev_sel;
    logic [3:0] rom_bits, prev_bits, lag = 4'h1;
    logic [STATE_NUM_W-1:0] state_num;
    logic [7:0] fetch_idx;
    logic [SEL_W-1:0] q[$];
    int bad_count = 0, n_checks = 0;
    always #50 ref_clk = ~ref_clk;
    load_sequencer load_sequencer_inst (.ref_clk, .rst, .update_request, .image_select,
        .busy, .load_strobe, .apply_strobe, .rom_bits, .mux_select, .image_bit, .state_num);
    ctl_model ctl_model_inst (.ref_clk, .rst, .load_strobe, .apply_strobe, .lag, .busy,
        .fetch_en, .fetch_idx, .rom_bits);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Request one image, then poke a request that must be ignored
    task automatic run_one(input logic [SEL_W-1:0] sel);
        do @(posedge ref_clk); while (state_num !== NUM_IDLE);
        lag <= 4'($urandom_range(1, 8));
        update_request <= 1'b1;
        image_select <= sel;
        q.push_back(sel);
        @(posedge ref_clk);
        update_request <= 1'b0;
        repeat (3) @(posedge ref_clk);
        update_request <= 1'b1;
        image_select <= sel + 2'h1;
        @(posedge ref_clk);
        update_request <= 1'b0;
    endtask
    // Result watcher: load strobe against notes, both strobes against state number, image path every cycle
    always @(posedge ref_clk) begin
        if (rst) live = 0;
        else begin
            if (live) chk(image_bit, prev_bits[prev_sel]);
            if (load_strobe === 1'b1) chk(mux_select, q.size() ? q.pop_front() : 8'hff);
            if (load_strobe === 1'b1) chk(state_num, NUM_LOAD);
            if (apply_strobe === 1'b1) chk(state_num, NUM_APPLY);
            prev_bits = rom_bits;
            prev_sel = mux_select;
            live = 1;
        end
    end
    initial begin
        #(100 * 8000);
        bad_count++;
        complete_run();
    end
    initial begin
        void'($urandom(32'hece77a1d));
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < NUM_IMAGES; i++) run_one(i[1:0]);
        run_one(2'($urandom));
        repeat (20) @(posedge ref_clk);
        rst <= 1'b1;
        @(posedge ref_clk);
        chk(state_num, NUM_IDLE);
        chk({load_strobe, apply_strobe}, 8'h00);
        rst <= 1'b0;
        run_one(2'h1);
        do @(posedge ref_clk); while (state_num !== NUM_IDLE);
        chk(q.size(), 8'h00);
        complete_run();
    end
endmodule
